//--- tfskip_core.sv
`timescale 1ns/1ns
`default_nettype none

module tfskip_core
	import tfskip_pkg::*;
(
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     instr_valid_i,
	input  wire logic [TFSKIP_IW-1:0]     instr_i,
	input  wire logic [TFSKIP_CTRL_W-1:0] int_control_reg_one_i,
	input  wire logic                     timer1_request_flag_i,
	input  wire logic                     timer2_request_flag_i,
	output logic                          timer1_flag_clear_o,
	output logic                          timer2_flag_clear_o,
	output logic                          squash_o,
	output logic                          skip_pending_o
);

	logic skip_r;
	logic skip_nxt;

	// Opcode match, shared by the decode and by the checks below.
	function automatic logic op_match(
		input logic [TFSKIP_IW-1:0] word,
		input logic [TFSKIP_IW-1:0] op
	);
		return word == op;
	endfunction

	// A word that arrives while a skip is pending is discarded and decodes
	// as nothing, so it cannot itself skip or clear a flag.
	wire logic live;
	wire logic is_t1;
	wire logic is_t2;
	wire logic timer1_int_enable_bit;
	wire logic timer2_int_enable_bit;
	wire logic hit1;
	wire logic hit2;

	assign live  = instr_valid_i & ~skip_r;
	assign is_t1 = live & op_match(instr_i, TFSKIP_OP_T1);
	assign is_t2 = live & op_match(instr_i, TFSKIP_OP_T2);
	assign timer1_int_enable_bit =
		int_control_reg_one_i[TFSKIP_T1_EN_POS];
	assign timer2_int_enable_bit =
		int_control_reg_one_i[TFSKIP_T2_EN_POS];
	assign hit1 = is_t1 & ~timer1_int_enable_bit
		& timer1_request_flag_i;
	assign hit2 = is_t2 & ~timer2_int_enable_bit
		& timer2_request_flag_i;

	assign timer1_flag_clear_o = hit1;
	assign timer2_flag_clear_o = hit2;

	// The pending skip lasts until the next valid word has been discarded.
	assign skip_nxt = (hit1 | hit2) ? 1'b1 :
	                  (instr_valid_i ? 1'b0 : skip_r);
	assign squash_o       = instr_valid_i & skip_r;
	assign skip_pending_o = skip_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			skip_r <= TFSKIP_SKIP_RST;
		end else begin
			skip_r <= skip_nxt;
		end
	end

	property p_t1_skip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && instr_i == TFSKIP_OP_T1
		 && !int_control_reg_one_i[TFSKIP_T1_EN_POS]
		 && timer1_request_flag_i)
		|-> timer1_flag_clear_o ##1 skip_r;
	endproperty
	a_t1_skip: assert property (p_t1_skip)
		else $error("t1 skip missed");

	property p_t1_noskip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && instr_i == TFSKIP_OP_T1
		 && !timer1_request_flag_i) |=> !skip_r;
	endproperty
	a_t1_noskip: assert property (p_t1_noskip)
		else $error("t1 false skip");

	property p_t1_nop;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		int_control_reg_one_i[TFSKIP_T1_EN_POS] |-> !timer1_flag_clear_o;
	endproperty
	a_t1_nop: assert property (p_t1_nop)
		else $error("t1 acted when enabled");

	property p_t1_clr;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		timer1_flag_clear_o
		|-> timer1_request_flag_i && instr_i == TFSKIP_OP_T1;
	endproperty
	a_t1_clr: assert property (p_t1_clr)
		else $error("t1 bad clear");

	property p_t2_skip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && instr_i == TFSKIP_OP_T2
		 && !int_control_reg_one_i[TFSKIP_T2_EN_POS]
		 && timer2_request_flag_i)
		|-> timer2_flag_clear_o ##1 skip_r;
	endproperty
	a_t2_skip: assert property (p_t2_skip)
		else $error("t2 skip missed");

	property p_t2_nop;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		int_control_reg_one_i[TFSKIP_T2_EN_POS] |-> !timer2_flag_clear_o;
	endproperty
	a_t2_nop: assert property (p_t2_nop)
		else $error("t2 acted when enabled");

	property p_t2_clr;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		timer2_flag_clear_o
		|-> timer2_request_flag_i && instr_i == TFSKIP_OP_T2;
	endproperty
	a_t2_clr: assert property (p_t2_clr)
		else $error("t2 bad clear");

	property p_discard;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(skip_r && instr_valid_i) |-> squash_o && !timer1_flag_clear_o
		&& !timer2_flag_clear_o ##1 !skip_r;
	endproperty
	a_discard: assert property (p_discard)
		else $error("skip not discarded");

	property p_en_pos;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && instr_i == TFSKIP_OP_T2
		 && int_control_reg_one_i == 4'h4 && timer2_request_flag_i)
		|-> timer2_flag_clear_o;
	endproperty
	a_en_pos: assert property (p_en_pos)
		else $error("t2 wrong enable bit");

	property p_en_pos1;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && instr_i == TFSKIP_OP_T1
		 && int_control_reg_one_i == 4'h8 && timer1_request_flag_i)
		|-> timer1_flag_clear_o;
	endproperty
	a_en_pos1: assert property (p_en_pos1)
		else $error("t1 wrong enable bit");

	property p_t1_nop_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && op_match(instr_i, TFSKIP_OP_T1)
		 && int_control_reg_one_i[TFSKIP_T1_EN_POS]) |=> !skip_r;
	endproperty
	a_t1_nop_hold: assert property (p_t1_nop_hold)
		else $error("t1 skipped when enabled");

	property p_t1_flag_low;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && op_match(instr_i, TFSKIP_OP_T1)
		 && !timer1_request_flag_i) |-> !timer1_flag_clear_o;
	endproperty
	a_t1_flag_low: assert property (p_t1_flag_low)
		else $error("t1 cleared an idle flag");

	property p_t2_noskip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && op_match(instr_i, TFSKIP_OP_T2)
		 && !timer2_request_flag_i) |=> !skip_r;
	endproperty
	a_t2_noskip: assert property (p_t2_noskip)
		else $error("t2 false skip");

	property p_t2_flag_low;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && op_match(instr_i, TFSKIP_OP_T2)
		 && !timer2_request_flag_i) |-> !timer2_flag_clear_o;
	endproperty
	a_t2_flag_low: assert property (p_t2_flag_low)
		else $error("t2 cleared an idle flag");

	property p_t2_nop_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(instr_valid_i && !skip_r && op_match(instr_i, TFSKIP_OP_T2)
		 && int_control_reg_one_i[TFSKIP_T2_EN_POS]) |=> !skip_r;
	endproperty
	a_t2_nop_hold: assert property (p_t2_nop_hold)
		else $error("t2 skipped when enabled");

	property p_t1_clr_once;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		timer1_flag_clear_o |=> !timer1_flag_clear_o;
	endproperty
	a_t1_clr_once: assert property (p_t1_clr_once)
		else $error("t1 clear held");

	property p_t2_clr_once;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		timer2_flag_clear_o |=> !timer2_flag_clear_o;
	endproperty
	a_t2_clr_once: assert property (p_t2_clr_once)
		else $error("t2 clear held");

	property p_idle;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!instr_valid_i |-> !timer1_flag_clear_o && !timer2_flag_clear_o
		&& !squash_o;
	endproperty
	a_idle: assert property (p_idle)
		else $error("action without a valid word");

	property p_gap_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(skip_r && !instr_valid_i) |=> skip_r;
	endproperty
	a_gap_hold: assert property (p_gap_hold)
		else $error("pending skip lost in a gap");

	property p_skip_src;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!skip_r && !timer1_flag_clear_o && !timer2_flag_clear_o)
		|=> !skip_r;
	endproperty
	a_skip_src: assert property (p_skip_src)
		else $error("skip without a test");

	property p_rst_clear;
		@(posedge core_clk_i)
		!rst_n_i |=> !skip_r;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("skip survived reset");

endmodule

`default_nettype wire

//--- tfskip_pkg.sv
package tfskip_pkg;

	// Instruction word width and opcodes of the two skip tests.
	localparam int          TFSKIP_IW          = 10;
	localparam logic [9:0]  TFSKIP_OP_T1       = 10'h280;
	localparam logic [9:0]  TFSKIP_OP_T2       = 10'h281;

	// Positions of the enable bits in the first interrupt control register.
	localparam int          TFSKIP_T1_EN_POS   = 2;
	localparam int          TFSKIP_T2_EN_POS   = 3;
	localparam int          TFSKIP_CTRL_W      = 4;

	// Reset values.
	localparam logic        TFSKIP_SKIP_RST    = 1'b0;

endpackage

//--- test_timer_flag_skip_test.sv
`timescale 1ns/1ns
`default_nettype none
module test_timer_flag_skip_test
	import tfskip_pkg::*;
;
	localparam logic [9:0] T1  = TFSKIP_OP_T1;
	localparam logic [9:0] T2  = TFSKIP_OP_T2;
	localparam logic [9:0] NOP = 10'h000;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       vld = 1'b0;
	logic [9:0] ins = 10'h000;
	logic [3:0] ctl = 4'h0;
	logic       f1 = 1'b0;
	logic       f2 = 1'b0;
	logic       c1, c2, sq, pd;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	tfskip_core u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(vld),
		.instr_i(ins), .int_control_reg_one_i(ctl), .timer1_request_flag_i(f1),
		.timer2_request_flag_i(f2), .timer1_flag_clear_o(c1),
		.timer2_flag_clear_o(c2), .squash_o(sq), .skip_pending_o(pd));

	always #5 clk = ~clk;

	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %b exp %b", $time, seen, exp);
		end
	endtask

	// One instruction slot; expected is {clear1, clear2, squash, pending}.
	task automatic step(input logic v, input logic [9:0] w, input logic [3:0] c,
		input logic a, input logic b, input logic [3:0] e);
		@(posedge clk);
		#1 {vld, ins, ctl, f1, f2} = {v, w, c, a, b};
		#4 chk({c1, c2, sq, pd}, e);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		step(1'b1, T1, 4'h8, 1'b1, 1'b0, 4'h8);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h3);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, T1, 4'h0, 1'b0, 1'b1, 4'h0);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, T1, 4'h4, 1'b1, 1'b0, 4'h0);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, T2, 4'h4, 1'b0, 1'b1, 4'h4);
		step(1'b0, T1, 4'h0, 1'b1, 1'b0, 4'h1);
		step(1'b1, T2, 4'h0, 1'b0, 1'b1, 4'h3);
		step(1'b1, T2, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, T2, 4'h8, 1'b0, 1'b1, 4'h0);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, 10'h282, 4'h0, 1'b1, 1'b1, 4'h0);
		step(1'b1, T1, 4'h0, 1'b1, 1'b1, 4'h8);
		step(1'b1, T2, 4'h0, 1'b1, 1'b1, 4'h3);
		step(1'b1, T1, 4'h0, 1'b1, 1'b0, 4'h8);
		step(1'b0, NOP, 4'h0, 1'b0, 1'b0, 4'h1);
		@(posedge clk);
		#1 rst_n = 1'b0;
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		@(posedge clk);
		#1 rst_n = 1'b1;
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h0);
		step(1'b1, T1, 4'h0, 1'b1, 1'b0, 4'h8);
		step(1'b1, NOP, 4'h0, 1'b0, 1'b0, 4'h3);
		finish_test();
	end
endmodule
`default_nettype wire
